// >>> logic/sar_adc_control_defines.vh
//
// Notes on behaviour
// - writing start bit begins conversion; hardware clears it
// - power bit on runs converter; off shuts down
// - format one: right justified, high six zero
// - format zero: left justified, low six zero
// - clock code picks divide or internal rc
// - port field decodes analog pins and references
// - reset forces shared pins to analog input
// - sleep conversion only on internal rc clock
// - result by successive approximation, ten steps
// - reset clears controls, powers off, aborts conversion
// - completion loads result, clears start, sets flag
// - power-on reset leaves result registers untouched
// - two bit periods before next acquisition
// - conversion start disconnects hold capacitor from pin
// - unimplemented control bits ignore writes, read zero
// - three-bit channel field selects input zero..seven
// - clearing start aborts, result kept, two-period wait
// - full conversion takes twelve bit periods
`ifndef SAR_ADC_CONTROL_DEFINES_VH
`define SAR_ADC_CONTROL_DEFINES_VH

// ***************************************************
// register byte addresses
// ***************************************************
`define OFS_CONTROL_0        5'h00
`define OFS_CONTROL_1        5'h04
`define OFS_RESULT_HIGH      5'h08
`define OFS_RESULT_LOW       5'h0c
`define OFS_DONE_IRQ         5'h10

// ***************************************************
// field positions
// ***************************************************
`define C0_POWER_BIT         0
`define C0_GO_BIT            2
`define C0_CHAN_LSB          3
`define C0_CLKSEL_LSB        6
`define C1_PCFG_LSB          0
`define C1_CLKSEL_HIGH_BIT   6
`define C1_FORMAT_BIT        7
`define IRQ_FLAG_BIT         0
`define IRQ_ENABLE_BIT       1

// ***************************************************
// reset values
// ***************************************************
`define CONTROL_0_RESET      8'h00
`define CONTROL_1_RESET      8'h00
`define PCFG_RESET           4'h0

// ***************************************************
// divider terminal counts (divisor minus one)
// ***************************************************
`define DIV_2_LAST           6'h01
`define DIV_4_LAST           6'h03
`define DIV_8_LAST           6'h07
`define DIV_16_LAST          6'h0f
`define DIV_32_LAST          6'h1f
`define DIV_64_LAST          6'h3f
`define CLKSEL_RC            2'h3

// ***************************************************
// sequence counts in bit periods
// ***************************************************
`define TAD_PER_CONV_LAST    4'hb
`define TAD_HOLDOFF_LAST     4'h1

`endif

// >>> logic/sar_adc_control.v
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`include "sar_adc_control_defines.vh"

module sar_adc_control #(
	parameter RES_W = 10
) (
	// clock and reset
	input  wire              clk_sys,
	input  wire              rst_n,
	// avalon-mm slave
	input  wire [4:0]        avs_address,
	input  wire              avs_read,
	input  wire              avs_write,
	input  wire [31:0]       avs_writedata,
	output reg  [31:0]       avs_readdata_q,
	output reg               avs_waitrequest_q,
	// device state
	input  wire              sleep_in,
	output reg               conv_irq_q,
	// analog core
	input  wire              rc_osc_in,
	input  wire              comparator_in,
	output reg               converter_power_on_q,
	output reg  [2:0]        input_channel_select_q,
	output reg               hold_connect_q,
	output reg  [RES_W-1:0]  sar_code_q,
	output reg  [7:0]        analog_input_q,
	output reg               vref_pos_ext_q,
	output reg               vref_neg_ext_q
);

	localparam [1:0] ST_IDLE    = 2'h0;
	localparam [1:0] ST_CONV    = 2'h1;
	localparam [1:0] ST_HOLDOFF = 2'h2;
	localparam [31:0] MSB_IDX   = RES_W - 1;

	// ***************************************************
	// registers
	// ***************************************************
	reg                  go_q;
	reg  [1:0]           clock_select_low_bits_q;
	reg                  clock_select_high_bit_q;
	reg                  result_format_select_q;
	reg  [3:0]           port_config_field_q;
	reg                  done_flag_q;
	reg                  done_irq_enable_q;
	reg  [7:0]           result_high_byte_q;
	reg  [7:0]           result_low_byte_q;
	reg  [1:0]           state_q;
	reg  [3:0]           tad_idx_q;
	reg  [3:0]           bit_idx_q;
	reg  [5:0]           div_cnt_q;
	reg                  rc_meta_q;
	reg                  rc_sync_q;
	reg                  rc_prev_q;
	reg                  cmp_meta_q;
	reg                  cmp_sync_q;

	reg  [5:0]           div_last;
	reg  [7:0]           analog_d;
	reg                  vpos_d;
	reg                  vneg_d;
	reg  [31:0]          rdata_d;
	reg                  go_d;
	reg                  flag_d;

	wire                 access_now = (avs_read | avs_write) & ~avs_waitrequest_q;
	wire                 wr_now     = avs_write & ~avs_waitrequest_q;
	wire                 wr_ctl0    = wr_now & (avs_address == `OFS_CONTROL_0);
	wire                 wr_ctl1    = wr_now & (avs_address == `OFS_CONTROL_1);
	wire                 wr_resh    = wr_now & (avs_address == `OFS_RESULT_HIGH);
	wire                 wr_resl    = wr_now & (avs_address == `OFS_RESULT_LOW);
	wire                 wr_irq     = wr_now & (avs_address == `OFS_DONE_IRQ);
	wire                 use_rc     = (clock_select_low_bits_q == `CLKSEL_RC);
	wire                 rc_tick    = rc_sync_q & ~rc_prev_q;
	wire                 fosc_tick  = (div_cnt_q == div_last) & ~sleep_in;
	wire                 tad_tick   = use_rc ? rc_tick : fosc_tick;
	wire                 converting = (state_q == ST_CONV);
	wire                 done_evt   = converting & go_q & tad_tick & (tad_idx_q == `TAD_PER_CONV_LAST);
	wire [7:0]           ctl0_rd    = {clock_select_low_bits_q, input_channel_select_q, go_q,
	                                   1'b0, converter_power_on_q};
	wire [7:0]           ctl1_rd    = {result_format_select_q, clock_select_high_bit_q, 2'h0, port_config_field_q};

	// ***************************************************
	// synchronisers
	// ***************************************************
	always @(posedge clk_sys) begin
		rc_meta_q  <= rc_osc_in;
		rc_sync_q  <= rc_meta_q;
		rc_prev_q  <= rc_sync_q;
		cmp_meta_q <= comparator_in;
		cmp_sync_q <= cmp_meta_q;
	end

	// ***************************************************
	// conversion clock select
	// ***************************************************
	always @* begin
		case ({clock_select_high_bit_q, clock_select_low_bits_q})
			3'h0:    div_last = `DIV_2_LAST;
			3'h1:    div_last = `DIV_8_LAST;
			3'h2:    div_last = `DIV_32_LAST;
			3'h4:    div_last = `DIV_4_LAST;
			3'h5:    div_last = `DIV_16_LAST;
			3'h6:    div_last = `DIV_64_LAST;
			default: div_last = `DIV_64_LAST;
		endcase
	end

	// divided oscillator stops in sleep, rc keeps running
	always @(posedge clk_sys) begin
		if (!rst_n || state_q == ST_IDLE || fosc_tick) begin
			div_cnt_q <= 6'h00;
		end else if (!sleep_in) begin
			div_cnt_q <= div_cnt_q + 6'h01;
		end
	end

	// ***************************************************
	// port configuration decode
	// ***************************************************
	always @* begin
		vpos_d = 1'b0;
		vneg_d = 1'b0;
		case (port_config_field_q)
			4'h0: analog_d = 8'hff;
			4'h1: begin
				analog_d = 8'hf7;
				vpos_d   = 1'b1;
			end
			4'h2: analog_d = 8'h1f;
			4'h3: begin
				analog_d = 8'h17;
				vpos_d   = 1'b1;
			end
			4'h4: analog_d = 8'h0b;
			4'h5: begin
				analog_d = 8'h03;
				vpos_d   = 1'b1;
			end
			4'h8: begin
				analog_d = 8'hf3;
				vpos_d   = 1'b1;
				vneg_d   = 1'b1;
			end
			4'h9: analog_d = 8'h3f;
			4'ha: begin
				analog_d = 8'h37;
				vpos_d   = 1'b1;
			end
			4'hb: begin
				analog_d = 8'h33;
				vpos_d   = 1'b1;
				vneg_d   = 1'b1;
			end
			4'hc: begin
				analog_d = 8'h13;
				vpos_d   = 1'b1;
				vneg_d   = 1'b1;
			end
			4'hd: begin
				analog_d = 8'h03;
				vpos_d   = 1'b1;
				vneg_d   = 1'b1;
			end
			4'he: analog_d = 8'h01;
			4'hf: begin
				analog_d = 8'h01;
				vpos_d   = 1'b1;
				vneg_d   = 1'b1;
			end
			default: analog_d = 8'h00;
		endcase
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			analog_input_q <= 8'hff;
			vref_pos_ext_q <= 1'b0;
			vref_neg_ext_q <= 1'b0;
		end else begin
			analog_input_q <= analog_d;
			vref_pos_ext_q <= vpos_d;
			vref_neg_ext_q <= vneg_d;
		end
	end

	// ***************************************************
	// control registers
	// ***************************************************
	always @* begin
		go_d = go_q;
		if (done_evt) begin
			go_d = 1'b0;
		end
		if (wr_ctl0) begin
			go_d = avs_writedata[`C0_GO_BIT] & converter_power_on_q;
		end
		if (!converter_power_on_q) begin
			go_d = 1'b0;
		end
		flag_d = done_flag_q;
		if (wr_irq) begin
			flag_d = avs_writedata[`IRQ_FLAG_BIT];
		end
		if (done_evt) begin
			flag_d = 1'b1;
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			go_q                    <= |(`CONTROL_0_RESET & (8'h01 << `C0_GO_BIT));
			converter_power_on_q    <= 1'b0;
			input_channel_select_q  <= 3'h0;
			clock_select_low_bits_q <= 2'h0;
			clock_select_high_bit_q <= 1'b0;
			result_format_select_q  <= 1'b0;
			port_config_field_q     <= `PCFG_RESET;
			done_flag_q             <= 1'b0;
			done_irq_enable_q       <= 1'b0;
			conv_irq_q              <= 1'b0;
		end else begin
			go_q        <= go_d;
			done_flag_q <= flag_d;
			conv_irq_q  <= flag_d & done_irq_enable_q;
			if (wr_ctl0) begin
				converter_power_on_q    <= avs_writedata[`C0_POWER_BIT];
				input_channel_select_q  <= avs_writedata[`C0_CHAN_LSB +: 3];
				clock_select_low_bits_q <= avs_writedata[`C0_CLKSEL_LSB +: 2];
			end
			if (wr_ctl1) begin
				port_config_field_q     <= avs_writedata[`C1_PCFG_LSB +: 4];
				clock_select_high_bit_q <= avs_writedata[`C1_CLKSEL_HIGH_BIT];
				result_format_select_q  <= avs_writedata[`C1_FORMAT_BIT];
			end
			if (wr_irq) begin
				done_irq_enable_q <= avs_writedata[`IRQ_ENABLE_BIT];
			end
		end
	end

	// ***************************************************
	// result registers, no reset
	// ***************************************************
	always @(posedge clk_sys) begin
		if (done_evt) begin
			if (result_format_select_q) begin
				result_high_byte_q <= {6'h00, sar_code_q[RES_W-1 -: 2]};
				result_low_byte_q  <= sar_code_q[7:0];
			end else begin
				result_high_byte_q <= sar_code_q[RES_W-1 -: 8];
				result_low_byte_q  <= {sar_code_q[1:0], 6'h00};
			end
		end else begin
			if (wr_resh) begin
				result_high_byte_q <= avs_writedata[7:0];
			end
			if (wr_resl) begin
				result_low_byte_q <= avs_writedata[7:0];
			end
		end
	end

	// ***************************************************
	// approximation sequencer
	// ***************************************************
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			state_q        <= ST_IDLE;
			tad_idx_q      <= 4'h0;
			bit_idx_q      <= 4'h0;
			sar_code_q     <= {RES_W{1'b0}};
			hold_connect_q <= 1'b0;
		end else if (!converter_power_on_q) begin
			state_q        <= ST_IDLE;
			hold_connect_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					hold_connect_q <= ~go_q;
					if (go_q) begin
						state_q        <= ST_CONV;
						tad_idx_q      <= 4'h0;
						bit_idx_q      <= MSB_IDX[3:0];
						sar_code_q     <= {1'b1, {(RES_W-1){1'b0}}};
						hold_connect_q <= 1'b0;
					end
				end
				ST_CONV: begin
					if (!go_q) begin
						state_q   <= ST_HOLDOFF;
						tad_idx_q <= 4'h0;
					end else if (tad_tick) begin
						tad_idx_q <= tad_idx_q + 4'h1;
						if (tad_idx_q == `TAD_PER_CONV_LAST) begin
							state_q   <= ST_HOLDOFF;
							tad_idx_q <= 4'h0;
						end else if (tad_idx_q != 4'h0) begin
							sar_code_q[bit_idx_q] <= cmp_sync_q;
							if (bit_idx_q != 4'h0) begin
								sar_code_q[bit_idx_q - 4'h1] <= 1'b1;
								bit_idx_q                    <= bit_idx_q - 4'h1;
							end
						end
					end
				end
				ST_HOLDOFF: begin
					if (tad_tick) begin
						tad_idx_q <= tad_idx_q + 4'h1;
						if (tad_idx_q == `TAD_HOLDOFF_LAST) begin
							state_q        <= ST_IDLE;
							hold_connect_q <= ~go_q;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ***************************************************
	// bus slave
	// ***************************************************
	always @* begin
		case (avs_address)
			`OFS_CONTROL_0:   rdata_d = {24'h000000, ctl0_rd};
			`OFS_CONTROL_1:   rdata_d = {24'h000000, ctl1_rd};
			`OFS_RESULT_HIGH: rdata_d = {24'h000000, result_high_byte_q};
			`OFS_RESULT_LOW:  rdata_d = {24'h000000, result_low_byte_q};
			`OFS_DONE_IRQ:    rdata_d = {30'h00000000, done_irq_enable_q, done_flag_q};
			default:          rdata_d = 32'h00000000;
		endcase
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			avs_waitrequest_q <= 1'b1;
			avs_readdata_q    <= 32'h00000000;
		end else begin
			if ((avs_read | avs_write) & avs_waitrequest_q) begin
				avs_waitrequest_q <= 1'b0;
				avs_readdata_q    <= rdata_d;
			end else begin
				avs_waitrequest_q <= 1'b1;
			end
			if (access_now && !avs_read) begin
				avs_readdata_q <= 32'h00000000;
			end
		end
	end

endmodule // sar_adc_control

// >>> tb/sar_adc_control_asserts.sv
`include "sar_adc_control_defines.vh"
module sar_adc_control_asserts #(
	parameter RES_W = 10
) (
	input wire             clk_sys,
	input wire             rst_n,
	input wire [4:0]       avs_address,
	input wire             avs_read,
	input wire             avs_write,
	input wire [31:0]      avs_writedata,
	input wire [31:0]      avs_readdata_q,
	input wire             avs_waitrequest_q,
	input wire             conv_irq_q,
	input wire             converter_power_on_q,
	input wire [2:0]       input_channel_select_q,
	input wire             hold_connect_q,
	input wire [RES_W-1:0] sar_code_q,
	input wire [7:0]       analog_input_q
);
	timeunit 1ns;
	timeprecision 1ps;
	// ***********************
	// bus and control checks
	// ***********************
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic [31:0] wd_q;
	always_ff @(posedge clk_sys) wd_q <= avs_writedata;
	wire rd_ack = avs_read && !avs_waitrequest_q;
	wire c0_wr = avs_write && !avs_waitrequest_q && avs_address == `OFS_CONTROL_0;
	sequence s_ack;
		!avs_waitrequest_q ##1 avs_waitrequest_q;
	endsequence
	property p_ack;
		(avs_read || avs_write) && avs_waitrequest_q |=> s_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("bus answer not one cycle");
	property p_rst;
		disable iff (1'b0) !rst_n |=> analog_input_q == 8'hff && !converter_power_on_q && !conv_irq_q
			&& !hold_connect_q && avs_waitrequest_q;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_start;
		$fell(hold_connect_q) && converter_power_on_q |-> sar_code_q == {1'b1, {(RES_W-1){1'b0}}};
	endproperty
	a_start: assert property (p_start) else $error("first trial not msb");
	property p_zero0;
		rd_ack && avs_address == `OFS_CONTROL_0 |-> avs_readdata_q[31:8] == 24'h0 && !avs_readdata_q[1];
	endproperty
	a_zero0: assert property (p_zero0) else $error("control 0 spare bit set");
	property p_zero1;
		rd_ack && avs_address == `OFS_CONTROL_1 |-> avs_readdata_q[5:4] == 2'h0;
	endproperty
	a_zero1: assert property (p_zero1) else $error("control 1 spare bits set");
	property p_unmap;
		rd_ack && avs_address > `OFS_DONE_IRQ |-> avs_readdata_q == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_chan;
		c0_wr |=> input_channel_select_q == wd_q[5:3];
	endproperty
	a_chan: assert property (p_chan) else $error("channel not updated");
	property p_pwr;
		c0_wr |=> converter_power_on_q == wd_q[0];
	endproperty
	a_pwr: assert property (p_pwr) else $error("power bit not updated");
endmodule // sar_adc_control_asserts
bind sar_adc_control sar_adc_control_asserts #(.RES_W(RES_W)) i_chk (.clk_sys, .rst_n, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_readdata_q, .avs_waitrequest_q, .conv_irq_q,
	.converter_power_on_q, .input_channel_select_q, .hold_connect_q, .sar_code_q, .analog_input_q);

// >>> tb/analog_core_model.sv
module analog_core_model (
	input  wire       clk_sys,
	input  wire       converter_power_on_q,
	input  wire [9:0] sar_code_q,
	input  wire [9:0] target,
	output logic      rc_osc_in,
	output logic      comparator_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// ***********************
	// rc clock and comparator
	// ***********************
	logic last_q = 1'b0;
	initial begin
		rc_osc_in = 1'b0;
		#7;
		forever #37 rc_osc_in = ~rc_osc_in;
	end
	always @(posedge clk_sys) last_q <= comparator_in;
	assign comparator_in = converter_power_on_q ? (target >= sar_code_q) : ~last_q;
endmodule // analog_core_model

// >>> tb/sar_adc_control_bench.sv
`include "sar_adc_control_defines.vh"
module sar_adc_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ***********************
	// signals and tasks
	// ***********************
	logic        clk_sys, rst_n, avs_read, avs_write, avs_waitrequest_q, sleep_in, conv_irq_q;
	logic        rc_osc_in, comparator_in, converter_power_on_q, hold_connect_q;
	logic        vref_pos_ext_q, vref_neg_ext_q;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata_q, r;
	logic [2:0]  input_channel_select_q;
	logic [9:0]  sar_code_q, target;
	logic [7:0]  analog_input_q;
	int          error_cnt = 0;
	int          n_checks = 0;
	int          n;
	string       nq[$];
	logic [31:0] eq[$];
	int          dv[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
	logic [9:0]  pc[16] = '{10'h3fc, 10'h3de, 10'h07c, 10'h05e, 10'h02c, 10'h00e, 10'h000, 10'h000,
		10'h3cf, 10'h0fc, 10'h0de, 10'h0cf, 10'h04f, 10'h00f, 10'h004, 10'h007};
	sar_adc_control i_dut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata_q, .avs_waitrequest_q, .sleep_in, .conv_irq_q, .rc_osc_in, .comparator_in,
		.converter_power_on_q, .input_channel_select_q, .hold_connect_q, .sar_code_q,
		.analog_input_q, .vref_pos_ext_q, .vref_neg_ext_q);
	analog_core_model i_core (.clk_sys, .converter_power_on_q, .sar_code_q, .target, .rc_osc_in,
		.comparator_in);
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (avs_waitrequest_q !== 1'b0 && k < 50);
		if (k >= 50) begin
			chk("waitrequest", 0, 1);
			give_verdict();
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] e);
		nq.push_back(nm);
		eq.push_back(e);
		bus(0, a, 32'h0);
	endtask
	task automatic wt(input bit h, input logic v, input int lim, output int k);
		k = 0;
		while ((h ? hold_connect_q : conv_irq_q) !== v && k < lim) begin
			@(posedge clk_sys);
			k++;
		end
		if (k >= lim) begin
			chk("wait", 32'(v), 32'(~v));
			give_verdict();
		end
	endtask
	task automatic conv(input logic [2:0] cs, input logic fm, input logic [9:0] t, input bit sl);
		logic [7:0] c0;
		int d;
		int k;
		c0 = {cs[1:0], 3'($urandom_range(7)), 3'h1};
		d = dv[cs];
		target <= t;
		bus(1, `OFS_CONTROL_1, {24'h0, fm, cs[2], 6'h0});
		bus(1, `OFS_CONTROL_0, {24'h0, c0});
		wt(1, 1'b1, 2000, k);
		bus(1, `OFS_CONTROL_0, {24'h0, c0 | 8'h04});
		chk("chan", 32'(c0[5:3]), 32'(input_channel_select_q));
		sleep_in <= sl;
		if (sl && d > 0) begin
			repeat (300) @(posedge clk_sys);
			chk("frozen", 0, 32'(conv_irq_q));
			sleep_in <= 1'b0;
		end
		wt(0, 1'b1, 3000, k);
		sleep_in <= 1'b0;
		if (d > 0 && !sl) chk("tad", 1, 32'(k >= 11 * d && k <= 12 * d + 6));
		rd("high", `OFS_RESULT_HIGH, fm ? {30'h0, t[9:8]} : {24'h0, t[9:2]});
		rd("low", `OFS_RESULT_LOW, fm ? {24'h0, t[7:0]} : {24'h0, t[1:0], 6'h0});
		rd("ctl0", `OFS_CONTROL_0, {24'h0, c0});
		rd("flag", `OFS_DONE_IRQ, 32'h3);
		bus(1, `OFS_DONE_IRQ, 32'h2);
		repeat (3) @(posedge clk_sys);
		chk("irq", 0, 32'(conv_irq_q));
	endtask
	always @(posedge clk_sys)
		if (avs_read && avs_waitrequest_q === 1'b0 && nq.size() > 0) chk(nq.pop_front(), eq.pop_front(), avs_readdata_q);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#900000;
		chk("run time", 0, 1);
		give_verdict();
	end
	// ***********************
	// main sequence
	// ***********************
	initial begin
		rst_n = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		sleep_in = 1'b0;
		target = 10'h000;
		r = $urandom(23150);
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		chk("analog", 32'h0ff, 32'(analog_input_q));
		rd("ctl0", `OFS_CONTROL_0, 32'h0);
		rd("ctl1", `OFS_CONTROL_1, 32'h0);
		rd("flag", `OFS_DONE_IRQ, 32'h0);
		$display("test reset done");
		bus(1, `OFS_CONTROL_0, 32'h06);
		rd("ctl0", `OFS_CONTROL_0, 32'h0);
		r = $urandom;
		bus(1, `OFS_CONTROL_1, r);
		rd("ctl1", `OFS_CONTROL_1, {24'h0, r[7:0] & 8'hcf});
		bus(1, `OFS_RESULT_HIGH, r);
		rd("gp high", `OFS_RESULT_HIGH, {24'h0, r[7:0]});
		bus(1, 5'h14, r);
		rd("unmapped", 5'h14, 32'h0);
		rd("unmapped", 5'h1c, 32'h0);
		for (int i = 0; i < 16; i++) begin
			bus(1, `OFS_CONTROL_1, 32'(i));
			repeat (2) @(posedge clk_sys);
			chk("pcfg", 32'(pc[i]), 32'({analog_input_q, vref_pos_ext_q, vref_neg_ext_q}));
		end
		$display("test registers done");
		bus(1, `OFS_DONE_IRQ, 32'h2);
		for (int c = 0; c < 8; c++) conv(3'(c), c[0], c == 0 ? {10{r[0]}} : 10'($urandom), 0);
		conv(3'h3, 1'b1, 10'($urandom), 1);
		conv(3'h1, 1'b0, 10'($urandom), 1);
		$display("test conversions done");
		bus(1, `OFS_CONTROL_1, 32'h40);
		bus(1, `OFS_RESULT_HIGH, 32'h5a);
		bus(1, `OFS_RESULT_LOW, 32'ha5);
		wt(1, 1'b1, 2000, n);
		bus(1, `OFS_CONTROL_0, 32'h85);
		repeat (300) @(posedge clk_sys);
		chk("hold", 0, 32'(hold_connect_q));
		bus(1, `OFS_CONTROL_0, 32'h81);
		wt(1, 1'b1, 400, n);
		chk("holdoff", 1, 32'(n >= 65 && n <= 140));
		rd("high", `OFS_RESULT_HIGH, 32'h5a);
		rd("low", `OFS_RESULT_LOW, 32'ha5);
		rd("flag", `OFS_DONE_IRQ, 32'h2);
		$display("test abort done");
		bus(1, `OFS_CONTROL_0, 32'h85);
		repeat (100) @(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		chk("power", 0, 32'(converter_power_on_q));
		chk("analog", 32'h0ff, 32'(analog_input_q));
		rd("ctl0", `OFS_CONTROL_0, 32'h0);
		rd("high", `OFS_RESULT_HIGH, 32'h5a);
		$display("test mid reset done");
		give_verdict();
	end
endmodule // sar_adc_control_bench
